// ---- design/fsc_map.vh ----
// command codes, status bit positions and bus timing for the flash sequencer host
`ifndef FSC_MAP_VH
`define FSC_MAP_VH
// command codes written on the low data byte
`define FSC_CMD_ERASE_SETUP 8'h20
`define FSC_CMD_ERASE_CONFIRM 8'hD0
`define FSC_CMD_WRITE_SETUP 8'h40
`define FSC_CMD_LOCK_SETUP 8'h60
`define FSC_CMD_LOCK_BLOCK 8'h01
`define FSC_CMD_LOCK_PERM 8'hF1
`define FSC_CMD_READ_ARRAY 8'hFF
// user operation codes
`define FSC_OP_ERASE 3'h0
`define FSC_OP_WRITE 3'h1
`define FSC_OP_LOCK_BLOCK 3'h2
`define FSC_OP_LOCK_PERM 3'h3
`define FSC_OP_CLR_STATUS 3'h4
`define FSC_OP_READ_ARRAY 3'h5
`define FSC_OP_POLL 3'h6
`define FSC_OP_ARRAY_READ 3'h7
// status word bit positions
`define FSC_SR_READY 7
`define FSC_SR_ERASE_PAUSED 6
`define FSC_SR_ERASE_ERR 5
`define FSC_SR_PROG_ERR 4
`define FSC_SR_SUPPLY_LOW 3
`define FSC_SR_PROG_PAUSED 2
`define FSC_SR_PROTECT 1
`define FSC_SR_RSVD 0
`define FSC_SR_ERR_MASK 8'h3A
`define FSC_SR_VALID_MASK 8'hFE
// bus timing in ns and derived 40 ns cycles, least times rounded up
`define FSC_CLK_NS 40
`define FSC_TWP_NS 50
`define FSC_TWPH_NS 20
`define FSC_TACC_NS 120
// counts sized to the 4-bit cycle counter so nothing is cut silently
`define FSC_TWP_CYC 4'h2
`define FSC_TWPH_CYC 4'h1
`define FSC_TACC_CYC 4'h3
`endif

// ---- design/fsc_host.v ----
// host-side command sequencer and status poller for a word-wide flash device
`timescale 1ns/100ps
`include "fsc_map.vh"
// Operation
// - host masks reserved status bit 0 out of every comparison
// - host ignores status bits 6..0 while bit 7 reads 0
// - host reads no lock states: no identifier read, and none from the status word
// - erase is 20H then D0H in block, then status reads
// - word write is 40H then data word, then status reads
// - lock set is 60H then 01H for block or F1H permanent
// - host writes FFH to return device to array-read mode
// - host issues clear-status after any error before retrying
// - host detects completion via ready/busy pin and status bit 7
// - host may check errors once after a series of operations
module fsc_host #(
  parameter [7:0] CLR_STATUS_CODE = 8'h50
) (
  // clock and reset
  input wire mclk_in,
  input wire srst_in,
  // user command port
  input wire cmd_valid_in,
  input wire [2:0] cmd_op_in,
  input wire [18:0] cmd_addr_in,
  input wire [15:0] cmd_data_in,
  input wire powerdown_in,
  output reg cmd_ready_out,
  output reg done_out,
  output reg refused_out,
  output reg error_out,
  output reg [7:0] status_out,
  output reg [15:0] read_data_out,
  // flash device pins
  output reg [18:0] flash_addr_out,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe_n_out,
  input wire [15:0] flash_dq_in,
  output reg flash_ce_n_out,
  output reg flash_oe_n_out,
  output reg flash_we_n_out,
  output reg reset_powerdown_out,
  input wire ready_busy_in
);

  // ----------------------------------------
  // states and helpers
  // ----------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_WSET = 7'h02;
  localparam [6:0] S_WLOW = 7'h04;
  localparam [6:0] S_WHIGH = 7'h08;
  localparam [6:0] S_RDWAIT = 7'h10;
  localparam [6:0] S_RDGAP = 7'h20;
  localparam [6:0] S_DONE = 7'h40;
  localparam [3:0] TWP_CYC = `FSC_TWP_CYC;
  localparam [3:0] TWPH_CYC = `FSC_TWPH_CYC;
  localparam [3:0] TACC_CYC = `FSC_TACC_CYC;

  // first command byte for each operation
  function [7:0] fsc_first_code;
    input [2:0] op;
    begin
      case (op)
        `FSC_OP_ERASE: fsc_first_code = `FSC_CMD_ERASE_SETUP;
        `FSC_OP_WRITE: fsc_first_code = `FSC_CMD_WRITE_SETUP;
        `FSC_OP_LOCK_BLOCK: fsc_first_code = `FSC_CMD_LOCK_SETUP;
        `FSC_OP_LOCK_PERM: fsc_first_code = `FSC_CMD_LOCK_SETUP;
        `FSC_OP_CLR_STATUS: fsc_first_code = CLR_STATUS_CODE;
        default: fsc_first_code = `FSC_CMD_READ_ARRAY;
      endcase
    end
  endfunction

  // confirm byte; word write confirm carries the data word itself
  function [15:0] fsc_second_word;
    input [2:0] op;
    input [15:0] data;
    begin
      case (op)
        `FSC_OP_ERASE: fsc_second_word = {8'h00, `FSC_CMD_ERASE_CONFIRM};
        `FSC_OP_WRITE: fsc_second_word = data;
        `FSC_OP_LOCK_BLOCK: fsc_second_word = {8'h00, `FSC_CMD_LOCK_BLOCK};
        default: fsc_second_word = {8'h00, `FSC_CMD_LOCK_PERM};
      endcase
    end
  endfunction

  // true for erase, write and lock: two writes then status polling
  function fsc_is_engine_op;
    input [2:0] op;
    begin
      fsc_is_engine_op = (op == `FSC_OP_ERASE) || (op == `FSC_OP_WRITE) ||
        (op == `FSC_OP_LOCK_BLOCK) || (op == `FSC_OP_LOCK_PERM);
    end
  endfunction

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  reg [6:0] state_ff;
  reg [2:0] op_ff;
  reg [15:0] second_ff;
  reg second_pending_ff;
  reg [3:0] cnt_ff;
  reg err_hold_ff;
  reg refuse_ff;
  wire [7:0] sr_seen;
  wire engine_op;
  wire needs_clear;

  // reserved bit forced to zero so masked and raw compares agree
  assign sr_seen = flash_dq_in[7:0] & `FSC_SR_VALID_MASK;
  assign engine_op = fsc_is_engine_op(cmd_op_in);
  // after an error only clear-status, polling and reads are taken
  assign needs_clear = err_hold_ff && fsc_is_engine_op(cmd_op_in);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (srst_in) begin
      state_ff <= S_IDLE;
      op_ff <= 3'h0;
      second_ff <= 16'h0000;
      second_pending_ff <= 1'b0;
      cnt_ff <= 4'h0;
      err_hold_ff <= 1'b0;
      refuse_ff <= 1'b0;
      cmd_ready_out <= 1'b0;
      done_out <= 1'b0;
      refused_out <= 1'b0;
      error_out <= 1'b0;
      status_out <= 8'h00;
      read_data_out <= 16'h0000;
      flash_addr_out <= 19'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n_out <= 1'b1;
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      reset_powerdown_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      refused_out <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          flash_ce_n_out <= 1'b1;
          flash_oe_n_out <= 1'b1;
          flash_we_n_out <= 1'b1;
          flash_dq_oe_n_out <= 1'b1;
          reset_powerdown_out <= ~powerdown_in;
          cmd_ready_out <= ~powerdown_in;
          if (powerdown_in) begin
            // reset pin low wipes the device status word, mirror it
            status_out <= 8'h00;
            err_hold_ff <= 1'b0;
          end
          if (cmd_valid_in && cmd_ready_out && !powerdown_in) begin
            cmd_ready_out <= 1'b0;
            op_ff <= cmd_op_in;
            flash_addr_out <= cmd_addr_in;
            second_ff <= fsc_second_word(cmd_op_in, cmd_data_in);
            second_pending_ff <= engine_op;
            if (needs_clear) begin
              // refusal is shown together with done so one strobe carries both
              refuse_ff <= 1'b1;
              state_ff <= S_DONE;
            end else if (cmd_op_in == `FSC_OP_POLL ||
                         cmd_op_in == `FSC_OP_ARRAY_READ) begin
              cnt_ff <= 4'h0;
              state_ff <= S_RDGAP;
            end else begin
              flash_dq_out <= {8'h00, fsc_first_code(cmd_op_in)};
              state_ff <= S_WSET;
            end
          end
        end
        S_WSET: begin
          // data and address settle before the write strobe falls
          flash_ce_n_out <= 1'b0;
          flash_dq_oe_n_out <= 1'b0;
          cnt_ff <= 4'h0;
          state_ff <= S_WLOW;
        end
        S_WLOW: begin
          flash_we_n_out <= 1'b0;
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == TWP_CYC) begin
            flash_we_n_out <= 1'b1;
            cnt_ff <= 4'h0;
            state_ff <= S_WHIGH;
          end
        end
        S_WHIGH: begin
          // data held past the rising strobe, then bus released unless a second word follows
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == TWPH_CYC) begin
            cnt_ff <= 4'h0;
            flash_ce_n_out <= 1'b1;
            if (second_pending_ff) begin
              second_pending_ff <= 1'b0;
              flash_dq_out <= second_ff;
              state_ff <= S_WSET;
            end else if (fsc_is_engine_op(op_ff)) begin
              flash_dq_oe_n_out <= 1'b1;
              state_ff <= S_RDGAP;
            end else begin
              flash_dq_oe_n_out <= 1'b1;
              if (op_ff == `FSC_OP_CLR_STATUS) begin
                err_hold_ff <= 1'b0;
                status_out <= 8'h00;
              end
              state_ff <= S_DONE;
            end
          end
        end
        S_RDGAP: begin
          flash_ce_n_out <= 1'b1;
          flash_oe_n_out <= 1'b1;
          cnt_ff <= 4'h0;
          // status reads pointless while the busy pin is still low
          if (ready_busy_in || op_ff == `FSC_OP_ARRAY_READ) begin
            flash_ce_n_out <= 1'b0;
            flash_oe_n_out <= 1'b0;
            state_ff <= S_RDWAIT;
          end
        end
        S_RDWAIT: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == TACC_CYC) begin
            flash_ce_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            if (op_ff == `FSC_OP_ARRAY_READ) begin
              read_data_out <= flash_dq_in;
              state_ff <= S_DONE;
            end else if (sr_seen[`FSC_SR_READY]) begin
              // lower bits only trusted once ready, errors accumulate
              status_out <= sr_seen;
              // protect bit is only an abort flag, lock states are never read from it
              if ((sr_seen & `FSC_SR_ERR_MASK) != 8'h00) begin
                err_hold_ff <= 1'b1;
              end
              state_ff <= S_DONE;
            end else begin
              state_ff <= S_RDGAP;
            end
          end
        end
        S_DONE: begin
          // sticky device bits make one check after a series enough
          done_out <= 1'b1;
          refused_out <= refuse_ff;
          refuse_ff <= 1'b0;
          error_out <= err_hold_ff |
            ((status_out & `FSC_SR_ERR_MASK) != 8'h00);
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- tb/fsc_host_assertions.sv ----
// port checks for the flash host sequencer
`timescale 1ns/100ps
module fsc_host_chk (
  // watched host ports
  input wire mclk_in,
  input wire srst_in,
  input wire cmd_valid_in,
  input wire [2:0] cmd_op_in,
  input wire powerdown_in,
  input wire cmd_ready_out,
  input wire done_out,
  input wire refused_out,
  input wire error_out,
  input wire [7:0] status_out,
  input wire [15:0] flash_dq_out,
  input wire flash_oe_n_out,
  input wire flash_we_n_out,
  input wire ready_busy_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // accepted request; with an error held the engine ops are refused instead
  wire take = cmd_valid_in && cmd_ready_out && !powerdown_in && !error_out;
  property p_rsv; !status_out[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("status bit 0 set");
  property p_keep; $changed(status_out) |-> status_out[7] || status_out == 8'h00; endproperty
  a_keep: assert property (p_keep) else $error("busy status kept");
  property p_ref; refused_out |-> done_out && error_out; endproperty
  a_ref: assert property (p_ref) else $error("refusal without error");
  property p_err; done_out && (status_out & 8'h3A) != 8'h00 |-> error_out; endproperty
  a_err: assert property (p_err) else $error("error not flagged");
  property p_twp;
    $fell(flash_we_n_out) |-> !flash_we_n_out [*2] ##[1:3] flash_we_n_out;
  endproperty
  a_twp: assert property (p_twp) else $error("write strobe width");
  property p_rbsy; $fell(flash_oe_n_out) |-> $past(ready_busy_in); endproperty
  a_rbsy: assert property (p_rbsy) else $error("read while busy");
  property p_ffc;
    take && cmd_op_in == 3'h5 |-> ##[1:20] (!flash_we_n_out && flash_dq_out == 16'h00FF);
  endproperty
  a_ffc: assert property (p_ffc) else $error("no array mode write");
  property p_ers;
    take && cmd_op_in == 3'h0 |-> ##[1:20] (!flash_we_n_out && flash_dq_out == 16'h0020)
      ##[1:20] (!flash_we_n_out && flash_dq_out == 16'h00D0);
  endproperty
  a_ers: assert property (p_ers) else $error("bad erase pair");
  property p_lck;
    take && cmd_op_in == 3'h3 |-> ##[1:20] (!flash_we_n_out && flash_dq_out == 16'h0060)
      ##[1:20] (!flash_we_n_out && flash_dq_out == 16'h00F1);
  endproperty
  a_lck: assert property (p_lck) else $error("bad lock pair");
  c_err: cover property (done_out && error_out);
  c_ref: cover property (refused_out);
  c_rd: cover property (take && cmd_op_in == 3'h7);
endmodule
bind fsc_host fsc_host_chk u_chk (.mclk_in(mclk_in), .srst_in(srst_in),
  .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .powerdown_in(powerdown_in),
  .cmd_ready_out(cmd_ready_out), .done_out(done_out), .refused_out(refused_out),
  .error_out(error_out), .status_out(status_out), .flash_dq_out(flash_dq_out),
  .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
  .ready_busy_in(ready_busy_in));

// ---- tb/fsc_dev.sv ----
// behavioural flash device: command decoder, write engine and status word
`timescale 1ns/100ps
module fsc_dev #(
  parameter BUSY_NS = 2010
) (
  // bus from the host
  input wire [18:0] addr_in,
  input wire [15:0] dq_in,
  input wire dq_oe_n_in,
  input wire ce_n_in,
  input wire oe_n_in,
  input wire we_n_in,
  input wire rp_in,
  input wire [7:0] inj_in,
  // pins back to the host
  output wire [15:0] dq_out,
  output wire ready_busy_out
);
  reg [6:0] err_ff = 7'h00;
  reg [7:0] setup_ff = 8'h00;
  reg busy_ff = 1'b0;
  reg arr_ff = 1'b1;
  reg [15:0] last_ff = 16'h0000;
  reg [15:0] mem [0:15];
  reg [7:0] s;
  wire [7:0] c = dq_in[7:0];
  wire rd = !ce_n_in && !oe_n_in;
  // low bits are junk while busy, so a host trusting them is caught
  wire [7:0] sr = {!busy_ff, busy_ff ? ~err_ff : err_ff};
  wire [15:0] word = arr_ff ? mem[addr_in[3:0]] : {8'h00, sr};
  // a released bus shows the inverse of the last word, never a stale copy
  assign dq_out = rd ? word : (!dq_oe_n_in ? dq_in : ~last_ff);
  assign ready_busy_out = !busy_ff;
  always @(posedge rd) last_ff = word;
  // commands latch on the rising write strobe
  always @(posedge we_n_in) begin
    if (!ce_n_in && rp_in && !busy_ff) begin
      s = setup_ff;
      setup_ff = 8'h00;
      arr_ff = s == 8'h00 && c == 8'hFF;
      if (s == 8'h40) begin
        mem[addr_in[3:0]] = dq_in;
        busy_ff = 1'b1;
      end else if (s == 8'h20 && c == 8'hD0 || s == 8'h60 && (c == 8'h01 || c == 8'hF1))
        busy_ff = 1'b1;
      else if (s != 8'h00)
        err_ff[5:4] = 2'b11;
      else if (c == 8'h50)
        err_ff = 7'h00;
      else if (c == 8'h20 || c == 8'h40 || c == 8'h60)
        setup_ff = c;
    end
  end
  // supply and locks are judged only when the engine ends, never tracked
  always @(posedge busy_ff) begin
    #(BUSY_NS);
    err_ff = err_ff | (inj_in[6:0] & 7'h3A);
    busy_ff = 1'b0;
  end
  // reset pin low wipes the status word and the decoder
  always @(negedge rp_in) begin
    err_ff = 7'h00;
    setup_ff = 8'h00;
    arr_ff = 1'b1;
    busy_ff = 1'b0;
  end
endmodule

// ---- tb/fsc_host_tb_top.sv ----
// self-checking bench for the flash host sequencer against a device model
`timescale 1ns/100ps
module fsc_host_tb_top;
  reg mclk_in = 1'b0;
  reg srst_in = 1'b1;
  reg cmd_valid_in = 1'b0;
  reg [2:0] cmd_op_in = 3'h0;
  reg [18:0] cmd_addr_in = 19'h00003;
  reg [15:0] cmd_data_in = 16'hA5C3;
  reg powerdown_in = 1'b0;
  reg [7:0] inj = 8'h00;
  reg r_ref;
  reg r_err;
  reg [2:0] k;
  integer n_fail = 0;
  integer n_tests = 0;
  wire cmd_ready_out, done_out, refused_out, error_out, ready_busy_in;
  wire flash_dq_oe_n_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, reset_powerdown_out;
  wire [7:0] status_out;
  wire [15:0] read_data_out, flash_dq_out, flash_dq_in;
  wire [18:0] flash_addr_out;
  // injected faults per engine op: erase, write, lock block, lock permanent
  wire [31:0] tab = 32'h12100028;
  always #20 mclk_in = ~mclk_in;
  fsc_host DUT (.mclk_in(mclk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
    .powerdown_in(powerdown_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
    .refused_out(refused_out), .error_out(error_out), .status_out(status_out),
    .read_data_out(read_data_out), .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n_out(flash_dq_oe_n_out),
    .flash_dq_in(flash_dq_in), .flash_ce_n_out(flash_ce_n_out),
    .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
    .reset_powerdown_out(reset_powerdown_out), .ready_busy_in(ready_busy_in));
  fsc_dev u_dev (.addr_in(flash_addr_out), .dq_in(flash_dq_out), .dq_oe_n_in(flash_dq_oe_n_out),
    .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
    .rp_in(reset_powerdown_out), .inj_in(inj), .dq_out(flash_dq_in),
    .ready_busy_out(ready_busy_in));
  task report_and_stop;
    begin
      if (n_fail == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // one command, held until taken, then waited on to its end
  task cmd(input [2:0] op);
    integer i;
    begin
      i = 0;
      cmd_op_in <= op;
      cmd_valid_in <= 1'b1;
      @(posedge mclk_in);
      while (cmd_ready_out !== 1'b1 && i < 100) begin
        @(posedge mclk_in);
        i = i + 1;
      end
      cmd_valid_in <= 1'b0;
      while (done_out !== 1'b1 && i < 3000) begin
        @(posedge mclk_in);
        i = i + 1;
      end
      // a command that never ends is a failure, not a silent skip
      if (done_out !== 1'b1) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: command never finished", $time);
      end
      r_ref = refused_out;
      r_err = error_out;
    end
  endtask
  // a hang is cut short well past the expected few hundred cycles
  initial begin
    #400000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge mclk_in);
    srst_in <= 1'b0;
    chk({8'h00, status_out}, 16'h0000);
    for (k = 3'h0; k < 3'h4; k = k + 3'h1) begin
      inj = tab[k * 8 +: 8];
      cmd(k);
      chk({8'h00, status_out}, {8'h00, inj | 8'h80});
      chk({15'h0000, r_err}, {15'h0000, inj != 8'h00});
      cmd(k);
      chk({15'h0000, r_ref}, {15'h0000, inj != 8'h00});
      cmd(3'h6);
      chk({8'h00, status_out}, {8'h00, inj | 8'h80});
      cmd(3'h4);
      chk({8'h00, status_out}, 16'h0000);
    end
    cmd(3'h5);
    cmd(3'h7);
    chk(read_data_out, 16'hA5C3);
    inj = 8'h20;
    cmd(3'h0);
    powerdown_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk({15'h0000, reset_powerdown_out}, 16'h0000);
    chk({8'h00, status_out}, 16'h0000);
    powerdown_in <= 1'b0;
    inj = 8'h00;
    cmd(3'h0);
    chk({8'h00, status_out}, 16'h0080);
    report_and_stop;
  end
endmodule
